// ---- include/pfs_pkg.sv ----
/*
 * Package for the power-fail and stop-mode sequencer: register map, field
 * positions, reset values, sequencing states and timing constants.
 * Assumes a 10 MHz system clock and an APB bus with 32-bit data.
 */
package pfs_pkg;
	// APB byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WAKE = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_STATE = 8'h10;
	// Control register fields
	localparam int CTRL_PFD = 0;
	localparam int CTRL_WARN_LO = 1;
	localparam int CTRL_POWERFAIL_IRQ_ENABLE = 3;
	localparam int CTRL_INT_LO = 4;
	localparam int CTRL_STOP = 6;
	// Status and mask bits
	localparam int STAT_W = 3;
	localparam int STAT_PF = 0;
	localparam int STAT_WAKE = 1;
	localparam int STAT_PFRST = 2;
	// Reset values
	localparam logic PFD_RST = 1'b1;
	localparam logic [1:0] WARN_SEL_RST = 2'h0;
	localparam logic [1:0] INTERVAL_RST = 2'h0;
	localparam logic [15:0] WAKE_PERIOD_RST = 16'h0000;
	// Periodic check intervals, in ring-oscillator clocks
	localparam logic [1:0] INT_CONT = 2'h0;
	localparam logic [13:0] INT_P11 = 14'h0800;
	localparam logic [13:0] INT_P12 = 14'h1000;
	localparam logic [13:0] INT_P13 = 14'h2000;
	localparam logic [2:0] CHECK_TICKS = 3'h2;
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int RING_HZ = 8000;
	localparam int WAKE_STEP_NS = 125_000;
	localparam int XTAL_EXIT_CYCLES = 20;
	localparam logic [4:0] XTAL_EXIT_LAST = 5'(XTAL_EXIT_CYCLES - 2);
	// Entry points after reset
	localparam logic [15:0] ROM_ENTRY = 16'h8000;
	localparam logic [15:0] APP_ENTRY = 16'h0000;

	// Comparator flags from the analog front end
	typedef struct packed {
		logic usbAbove3v;
		logic usbAboveBatt;
		logic battBelowPor;
		logic battBelowReset;
		logic [3:0] battBelowWarn;
	} pfs_cmp_t;

	typedef enum logic [3:0] {
		S_POR = 4'h0,
		S_WARM = 4'h1,
		S_RUN = 4'h2,
		S_STOP = 4'h3,
		S_WAKE = 4'h4,
		S_PFSLEEP = 4'h5,
		S_PFCHK = 4'h6,
		S_PFCONF = 4'h7,
		S_EXT = 4'h8
	} pfs_state_t;
endpackage : pfs_pkg

// ---- hw/pfs_sequencer.sv ----
/*
 * Power-fail monitor, supply selection, stop mode and reset sequencer with
 * an APB register slave and two level interrupt outputs, pfIrq and irq.
 * Assumes comparator flags, ring-oscillator level and request inputs are
 * asynchronous levels; arst_n is the power-on reset; the crystal clocks clk_sys.
 */
// Design decisions made here: the register addresses and the APB slave port.
// Behaviour
// - Take USB supply when above 3.0V or above battery, else battery.
// - Battery failure raises the power-fail flag only when not bus powered.
// - Bus failure without battery switches to battery and raises the flag.
// - Stop halts the CPU; wakes on I/O, warning, timer or power-fail reset.
// - Wake timer counts 8kHz ring ticks of 125us and ends stop mode.
// - Stop-mode monitor disable bit resets to one.
// - With monitor disabled in stop, only power-on reset is detected.
// - On stop exit monitor enables; warning sets flag, reset level resets CPU.
// - Outside stop the monitor is always on; the code turns it off in POR and in S_PFSLEEP between power-fail checks.
// - Warning selector codes pick 1.8, 1.9, 2.55, 2.75 volt comparators.
// - Warning selector returns to 1.8V only on power-on reset.
// - Flag sets after warning persists for the persistence time.
// - Power-fail reset checks continuously or every 2^11, 2^12, 2^13 ticks.
// - Check two ticks, confirm one more, then warm up and start at 8000h.
// - In power-fail reset regulator and crystal off, SRAM retained.
// - Pin or watchdog reset keeps everything on; exit within 20 cycles.
// - Below power-on threshold the device is held in reset.
`timescale 1ns/1ps
module pfs_sequencer #(
	parameter int WARN_PERSIST_NS = 10_000,
	parameter int WARN_PERSIST_CYC = (WARN_PERSIST_NS * (pfs_pkg::CLK_HZ / 1_000_000)
		+ 999) / 1000
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pfs_pkg::pfs_cmp_t cmpFlags,
	input wire logic ringOsc,
	input wire logic xtalReady,
	input wire logic extResetReq,
	input wire logic ioIrqReq,
	output logic supplyFromUsb,
	output logic cpuReset_n,
	output logic cpuHalted,
	output logic monitorOn,
	output logic regulatorOn,
	output logic crystalOn,
	output logic sramRetain,
	output logic [15:0] resetVector,
	output logic pfIrq,
	output logic irq
);
	typedef struct packed {
		pfs_pkg::pfs_cmp_t cmpS1;
		pfs_pkg::pfs_cmp_t cmpS2;
		logic [2:0] ringS;
		logic [1:0] extS;
		logic [1:0] ioS;
		pfs_pkg::pfs_state_t st;
		logic stop_monitor_disable;
		logic [1:0] warnSel;
		logic powerfail_irq_enable;
		logic [1:0] intervalSel;
		logic stopReq;
		logic [15:0] wakePeriod;
		logic [pfs_pkg::STAT_W-1:0] stat;
		logic [pfs_pkg::STAT_W-1:0] mask;
		logic [pfs_pkg::STAT_W-1:0] rdClr;
		logic [31:0] rdData;
		logic [15:0] persistCnt;
		logic [13:0] ringCnt;
		logic [15:0] wakeCnt;
		logic [4:0] seqCnt;
		logic bootRom;
	} pfs_regs_t;

	// Synchronisers start pessimistic, so the sequencer cannot leave POR on reset values
	localparam pfs_pkg::pfs_cmp_t CMP_RST = '{usbAbove3v: 1'b0, usbAboveBatt: 1'b0,
		battBelowPor: 1'b1, battBelowReset: 1'b1, battBelowWarn: 4'hF};

	localparam pfs_regs_t REGS_RST = '{
		cmpS1: CMP_RST, cmpS2: CMP_RST, ringS: 3'h0, extS: 2'h0, ioS: 2'h0,
		st: pfs_pkg::S_POR, stop_monitor_disable: pfs_pkg::PFD_RST, warnSel: pfs_pkg::WARN_SEL_RST,
		powerfail_irq_enable: 1'b0, intervalSel: pfs_pkg::INTERVAL_RST, stopReq: 1'b0,
		wakePeriod: pfs_pkg::WAKE_PERIOD_RST, stat: '0, mask: '0, rdClr: '0,
		rdData: 32'h0000_0000, persistCnt: 16'h0000, ringCnt: 14'h0000,
		wakeCnt: 16'h0000, seqCnt: 5'h00, bootRom: 1'b0
	};
	localparam logic [15:0] PERSIST_LAST = 16'(WARN_PERSIST_CYC - 1);
	// Pin sampling and two synchroniser flops eat into the exit budget
	localparam logic [4:0] EXT_EXIT_LAST = pfs_pkg::XTAL_EXIT_LAST - 5'h04;

	pfs_regs_t q;
	pfs_regs_t d;
	pfs_pkg::pfs_cmp_t cmp;
	logic fromUsb;
	logic warnLow;
	logic rstLow;
	logic porLow;
	logic ringTick;
	logic extRst;
	logic ioIrq;
	logic apbWr;
	logic apbSetup;
	logic addrOk;
	logic [13:0] period;
	logic [pfs_pkg::STAT_W-1:0] ev;
	logic wakeExpired;

	// Decoded views of the synchronised inputs
	always_comb begin
		cmp = q.cmpS2;
		fromUsb = cmp.usbAbove3v | cmp.usbAboveBatt;
		// battery comparators count only off bus power
		warnLow = ~fromUsb & cmp.battBelowWarn[q.warnSel];
		rstLow = ~fromUsb & cmp.battBelowReset;
		porLow = ~fromUsb & cmp.battBelowPor;
		ringTick = q.ringS[1] & ~q.ringS[2];
		extRst = q.extS[1];
		ioIrq = q.ioS[1];
		apbSetup = psel & ~penable;
		apbWr = psel & penable & pwrite;
		addrOk = (paddr == pfs_pkg::ADDR_CTRL) || (paddr == pfs_pkg::ADDR_WAKE) ||
			(paddr == pfs_pkg::ADDR_STAT) || (paddr == pfs_pkg::ADDR_MASK) ||
			(paddr == pfs_pkg::ADDR_STATE);
		wakeExpired = (q.wakePeriod != 16'h0000) && ringTick &&
			(q.wakeCnt == q.wakePeriod - 16'h0001);
		unique case (q.intervalSel)
			2'h1: period = pfs_pkg::INT_P11;
			2'h2: period = pfs_pkg::INT_P12;
			2'h3: period = pfs_pkg::INT_P13;
			default: period = 14'h0001;
		endcase
	end

	// Next-state logic: synchronisers, sequencer, registers, status
	always_comb begin
		d = q;
		ev = '0;
		d.cmpS1 = cmpFlags;
		d.cmpS2 = q.cmpS1;
		d.ringS = {q.ringS[1:0], ringOsc};
		d.extS = {q.extS[0], extResetReq};
		d.ioS = {q.ioS[0], ioIrqReq};
		d.stopReq = 1'b0;

		// persistence filter between reset and warning levels
		if ((q.st == pfs_pkg::S_RUN) && warnLow && !rstLow) begin
			// Saturate one past the last count so the event fires once
			if (q.persistCnt != PERSIST_LAST + 16'h0001) begin
				d.persistCnt = q.persistCnt + 16'h0001;
			end
			if (q.persistCnt == PERSIST_LAST) begin
				ev[pfs_pkg::STAT_PF] = 1'b1;
			end
		end else begin
			d.persistCnt = 16'h0000;
		end

		unique case (q.st)
			pfs_pkg::S_POR: begin
				if (!porLow) begin
					d.st = pfs_pkg::S_WARM;
				end
			end
			pfs_pkg::S_WARM: begin
				if (xtalReady) begin
					d.st = pfs_pkg::S_RUN;
				end
			end
			pfs_pkg::S_RUN: begin
				// monitor acts here regardless of the disable bit
				if (rstLow) begin
					d.st = pfs_pkg::S_PFSLEEP;
					d.ringCnt = 14'h0000;
					d.bootRom = 1'b1;
					ev[pfs_pkg::STAT_PFRST] = 1'b1;
				end else if (extRst) begin
					d.st = pfs_pkg::S_EXT;
					d.seqCnt = 5'h00;
				end else if (q.stopReq) begin
					d.st = pfs_pkg::S_STOP;
					d.wakeCnt = 16'h0000;
				end
			end
			pfs_pkg::S_STOP: begin
				if (ringTick) begin
					d.wakeCnt = q.wakeCnt + 16'h0001;
				end
				// wake sources; monitor only when not disabled
				if (!q.stop_monitor_disable && rstLow) begin
					d.st = pfs_pkg::S_PFSLEEP;
					d.ringCnt = 14'h0000;
					d.bootRom = 1'b1;
					ev[pfs_pkg::STAT_PFRST] = 1'b1;
				end else if (extRst) begin
					d.st = pfs_pkg::S_EXT;
					d.seqCnt = 5'h00;
				end else if (ioIrq || wakeExpired || (!q.stop_monitor_disable && warnLow)) begin
					d.st = pfs_pkg::S_WAKE;
					ev[pfs_pkg::STAT_WAKE] = wakeExpired;
				end
			end
			pfs_pkg::S_WAKE: begin
				// monitor on before code runs, checked at exit
				if (rstLow) begin
					d.st = pfs_pkg::S_PFSLEEP;
					d.ringCnt = 14'h0000;
					d.bootRom = 1'b1;
					ev[pfs_pkg::STAT_PFRST] = 1'b1;
				end else if (xtalReady) begin
					d.st = pfs_pkg::S_RUN;
					ev[pfs_pkg::STAT_PF] = warnLow;
				end
			end
			pfs_pkg::S_PFSLEEP: begin
				if (q.intervalSel == pfs_pkg::INT_CONT) begin
					d.st = pfs_pkg::S_PFCHK;
					d.seqCnt = 5'h00;
				end else if (ringTick) begin
					d.ringCnt = q.ringCnt + 14'h0001;
					if (q.ringCnt == period - 14'h0001) begin
						d.st = pfs_pkg::S_PFCHK;
						d.seqCnt = 5'h00;
					end
				end
			end
			pfs_pkg::S_PFCHK: begin
				if (rstLow) begin
					d.st = pfs_pkg::S_PFSLEEP;
					d.ringCnt = 14'h0000;
				end else if (ringTick) begin
					d.seqCnt = q.seqCnt + 5'h01;
					if (q.seqCnt == 5'(pfs_pkg::CHECK_TICKS - 3'h1)) begin
						d.st = pfs_pkg::S_PFCONF;
					end
				end
			end
			pfs_pkg::S_PFCONF: begin
				// one more period above the reset level
				if (rstLow) begin
					d.st = pfs_pkg::S_PFSLEEP;
					d.ringCnt = 14'h0000;
				end else if (ringTick) begin
					d.st = pfs_pkg::S_WARM;
				end
			end
			pfs_pkg::S_EXT: begin
				// fixed short exit after the source goes away
				if (extRst) begin
					d.seqCnt = 5'h00;
				end else if (q.seqCnt == EXT_EXIT_LAST) begin
					d.st = pfs_pkg::S_RUN;
					d.bootRom = 1'b0;
				end else begin
					d.seqCnt = q.seqCnt + 5'h01;
				end
			end
			default: begin
				d.st = pfs_pkg::S_POR;
			end
		endcase

		// APB read data captured in the setup phase
		if (apbSetup) begin
			d.rdClr = '0;
			unique case (paddr)
				pfs_pkg::ADDR_CTRL: d.rdData = {25'h0, 1'b0, q.intervalSel, q.powerfail_irq_enable,
					q.warnSel, q.stop_monitor_disable};
				pfs_pkg::ADDR_WAKE: d.rdData = {16'h0000, q.wakePeriod};
				pfs_pkg::ADDR_STAT: begin
					d.rdData = {29'h0, q.stat};
					d.rdClr = pwrite ? '0 : q.stat;
				end
				pfs_pkg::ADDR_MASK: d.rdData = {29'h0, q.mask};
				pfs_pkg::ADDR_STATE: d.rdData = {24'h0, q.bootRom, rstLow, warnLow,
					fromUsb, q.st};
				default: d.rdData = 32'h0000_0000;
			endcase
		end

		// Register writes in the access phase
		if (apbWr) begin
			unique case (paddr)
				pfs_pkg::ADDR_CTRL: begin
					d.stop_monitor_disable = pwdata[pfs_pkg::CTRL_PFD];
					d.warnSel = pwdata[pfs_pkg::CTRL_WARN_LO +: 2];
					d.powerfail_irq_enable = pwdata[pfs_pkg::CTRL_POWERFAIL_IRQ_ENABLE];
					d.intervalSel = pwdata[pfs_pkg::CTRL_INT_LO +: 2];
					d.stopReq = pwdata[pfs_pkg::CTRL_STOP];
				end
				pfs_pkg::ADDR_WAKE: d.wakePeriod = pwdata[15:0];
				pfs_pkg::ADDR_MASK: d.mask = pwdata[pfs_pkg::STAT_W-1:0];
				default: begin
				end
			endcase
		end

		// Read clears only what was read; a new event wins over the clear
		if (psel && penable && !pwrite && (paddr == pfs_pkg::ADDR_STAT)) begin
			d.stat = (q.stat & ~q.rdClr) | ev;
		end else begin
			d.stat = q.stat | ev;
		end

		// power-on level restores every default except the synchronisers, warning level too
		if (porLow) begin
			d = REGS_RST;
			d.cmpS1 = cmpFlags;
			d.cmpS2 = q.cmpS1;
			d.ringS = {q.ringS[1:0], ringOsc};
			d.extS = {q.extS[0], extResetReq};
			d.ioS = {q.ioS[0], ioIrqReq};
		end
	end

	// State register; the power-on reset is the only asynchronous one
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			// disable bit and selector take defaults here
			q <= REGS_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs decoded from the state register
	always_comb begin
		pready = 1'b1;
		pslverr = psel & penable & ~addrOk;
		prdata = q.rdData;
		supplyFromUsb = fromUsb;
		cpuReset_n = (q.st == pfs_pkg::S_RUN) || (q.st == pfs_pkg::S_STOP) ||
			(q.st == pfs_pkg::S_WAKE);
		cpuHalted = (q.st == pfs_pkg::S_STOP) || (q.st == pfs_pkg::S_WAKE);
		// supplies off while parked in power-fail reset or stop
		regulatorOn = (q.st == pfs_pkg::S_WARM) || (q.st == pfs_pkg::S_RUN) ||
			(q.st == pfs_pkg::S_WAKE) || (q.st == pfs_pkg::S_EXT);
		crystalOn = regulatorOn;
		sramRetain = (q.st != pfs_pkg::S_POR);
		monitorOn = (q.st != pfs_pkg::S_POR) && (q.st != pfs_pkg::S_PFSLEEP) &&
			!((q.st == pfs_pkg::S_STOP) && q.stop_monitor_disable);
		resetVector = q.bootRom ? pfs_pkg::ROM_ENTRY : pfs_pkg::APP_ENTRY;
		pfIrq = q.stat[pfs_pkg::STAT_PF] & q.powerfail_irq_enable;
		irq = |(q.stat & q.mask);
	end

	a_supply_pick: assert property (@(posedge clk_sys) disable iff (!arst_n)
		supplyFromUsb == ($past(cmpFlags.usbAbove3v, 2) | $past(cmpFlags.usbAboveBatt, 2)))
		else $error("supply source does not follow USB comparators");
	a_usb_noevent: assert property (@(posedge clk_sys) disable iff (!arst_n)
		supplyFromUsb && $stable(supplyFromUsb) |=> !$rose(q.stat[pfs_pkg::STAT_PF]))
		else $error("power-fail flag raised while bus powered");
	a_timer_wake: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(q.stat[pfs_pkg::STAT_WAKE]) |-> $past(q.st) == pfs_pkg::S_STOP &&
		q.st == pfs_pkg::S_WAKE)
		else $error("wake timer flag without stop exit");
	a_stop_monoff: assert property (@(posedge clk_sys) disable iff (!arst_n)
		q.st == pfs_pkg::S_STOP && q.stop_monitor_disable |-> !monitorOn && cpuHalted)
		else $error("monitor on in stop while disabled");
	a_run_monon: assert property (@(posedge clk_sys) disable iff (!arst_n)
		q.st == pfs_pkg::S_RUN |-> monitorOn && cpuReset_n && !cpuHalted)
		else $error("monitor off during normal operation");
	a_warn_persist: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(q.stat[pfs_pkg::STAT_PF]) && $past(q.st) == pfs_pkg::S_RUN |->
		$past(q.persistCnt) == PERSIST_LAST)
		else $error("power-fail flag set before persistence time");
	a_pf_parked: assert property (@(posedge clk_sys) disable iff (!arst_n)
		q.st inside {pfs_pkg::S_PFSLEEP, pfs_pkg::S_PFCHK, pfs_pkg::S_PFCONF} |->
		!regulatorOn && !crystalOn && sramRetain && !cpuReset_n)
		else $error("supplies on or CPU out of reset in power-fail reset");
	a_ext_exit: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$fell(q.extS[1]) && q.st == pfs_pkg::S_EXT && !porLow |-> ##[1:17] cpuReset_n)
		else $error("no exit within 20 cycles of reset removal");
	a_por_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		porLow |=> !cpuReset_n && q.st == pfs_pkg::S_POR)
		else $error("CPU not held below power-on level");
	a_boot_rom: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$past(q.st) == pfs_pkg::S_PFCONF && q.st == pfs_pkg::S_WARM |->
		resetVector == pfs_pkg::ROM_ENTRY)
		else $error("power-fail exit not from ROM entry");
endmodule : pfs_sequencer

// ---- tb/pfs_analog_model.sv ----
/* Partner model: supply comparators, ring oscillator and crystal.
   Assumes the bench sets supplies in millivolts just after clk_sys edges. */
`timescale 1ns/1ps
module pfs_analog_model #(
	parameter int POR_MV = 1500,
	parameter int RST_MV = 1700,
	parameter int RING_HALF = 625,
	parameter int WARM_CYC = 30
) (
	input wire logic clk_sys,
	input wire logic crystalOn,
	input wire logic [15:0] battMv,
	input wire logic [15:0] usbMv,
	output pfs_pkg::pfs_cmp_t cmpFlags,
	output logic ringOsc,
	output logic xtalReady
);
	int ringCnt = 0;
	int warmCnt = 0;
	initial ringOsc = 1'b0;
	initial xtalReady = 1'b0;
	// Comparators are plain levels; the sequencer does the syncing
	assign cmpFlags.usbAbove3v = usbMv > 16'd3000;
	assign cmpFlags.usbAboveBatt = usbMv > battMv;
	assign cmpFlags.battBelowPor = battMv < 16'(POR_MV);
	assign cmpFlags.battBelowReset = battMv < 16'(RST_MV);
	assign cmpFlags.battBelowWarn = {battMv < 16'd2750, battMv < 16'd2550,
		battMv < 16'd1900, battMv < 16'd1800};
	// Ring runs free, also outside stop mode
	always @(posedge clk_sys) begin
		ringCnt <= (ringCnt == RING_HALF - 1) ? 0 : ringCnt + 1;
		if (ringCnt == RING_HALF - 1) begin
			ringOsc <= ~ringOsc;
		end
	end
	// Crystal is only ready after a warm-up since it was switched on
	always @(posedge clk_sys) begin
		warmCnt <= crystalOn ? ((warmCnt < WARM_CYC) ? warmCnt + 1 : warmCnt) : 0;
		xtalReady <= crystalOn && (warmCnt >= WARM_CYC);
	end
endmodule : pfs_analog_model

// ---- tb/pfs_sequencer_test.sv ----
/* Self-checking bench for the power-fail sequencer.
   Assumes pfs_pkg and the analog partner model are compiled first. */
`timescale 1ns/1ps
module pfs_sequencer_test;
	int warnMv[4] = '{1800, 1900, 2550, 2750};
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic extResetReq = 1'b0;
	logic ioIrqReq = 1'b0;
	logic [15:0] battMv = 16'h0CE4;
	logic [15:0] usbMv = 16'h0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, errv, ringOsc, xtalReady, supplyFromUsb, cpuReset_n;
	logic cpuHalted, monitorOn, regulatorOn, crystalOn, sramRetain, pfIrq, irq;
	logic [15:0] resetVector;
	pfs_pkg::pfs_cmp_t cmpFlags;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	int wcnt;
	always #50 clk_sys = ~clk_sys;
	pfs_sequencer #(.WARN_PERSIST_NS(200)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpFlags(cmpFlags),
		.ringOsc(ringOsc), .xtalReady(xtalReady), .extResetReq(extResetReq),
		.ioIrqReq(ioIrqReq), .supplyFromUsb(supplyFromUsb), .cpuReset_n(cpuReset_n),
		.cpuHalted(cpuHalted), .monitorOn(monitorOn), .regulatorOn(regulatorOn),
		.crystalOn(crystalOn), .sramRetain(sramRetain), .resetVector(resetVector),
		.pfIrq(pfIrq), .irq(irq));
	pfs_analog_model #(.RING_HALF(20)) ana_u (.clk_sys(clk_sys), .crystalOn(crystalOn),
		.battMv(battMv), .usbMv(usbMv), .cmpFlags(cmpFlags), .ringOsc(ringOsc),
		.xtalReady(xtalReady));
	// Hang guard, far above the roughly one thousand cycles the tests need
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle
	// Setup then access; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rdv);
	endtask : rdc
	task automatic setv(input int b, input int u);
		@(posedge clk_sys);
		battMv <= 16'(b);
		usbMv <= 16'(u);
	endtask : setv
	task automatic waitfor(ref logic s, input logic v, input int lim);
		wcnt = 0;
		while (s !== v && wcnt < lim) begin
			wcnt++;
			@(posedge clk_sys);
		end
	endtask : waitfor
	// Main sequence; expectations come from the supply and threshold model
	initial begin
		int b;
		int u;
		void'($urandom(32'h36D5D911));
		idle(20);
		arst_n <= 1'b1;
		waitfor(cpuReset_n, 1'b1, 3000);
		rdc("ctrl", pfs_pkg::ADDR_CTRL, 32'h1);
		rdc("mask", pfs_pkg::ADDR_MASK, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		chk("slverr", 32'h1, 32'(errv));
		for (int i = 0; i < 8; i++) begin
			b = $urandom_range(3600, 1800);
			u = $urandom_range(5000, 0);
			setv(b, u);
			idle(6);
			chk("fromUsb", 32'(u > 3000 || u > b), 32'(supplyFromUsb));
		end
		setv(3300, 0);
		$display("test reset and supply done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, pfs_pkg::ADDR_CTRL, 32'(1 + 2 * c));
			apb(1'b1, pfs_pkg::ADDR_CTRL, 32'(9 + 2 * c));
			setv(warnMv[c] + 20, 0);
			idle(20);
			chk("pfIrqAbove", 32'h0, 32'(pfIrq));
			setv(warnMv[c] - 20, 0);
			idle(20);
			chk("pfIrq", 32'h1, 32'(pfIrq));
			setv(3300, 0);
			rdc("statWarn", pfs_pkg::ADDR_STAT, 32'h1);
			apb(1'b1, pfs_pkg::ADDR_CTRL, 32'(1 + 2 * c));
		end
		apb(1'b1, pfs_pkg::ADDR_CTRL, 32'h1);
		setv(3300, 5000);
		idle(5);
		setv(1600, 5000);
		idle(20);
		chk("busRst", 32'h1, 32'(cpuReset_n));
		rdc("statBus", pfs_pkg::ADDR_STAT, 32'h0);
		setv(1750, 0);
		idle(20);
		setv(3300, 0);
		rdc("statBusFail", pfs_pkg::ADDR_STAT, 32'h1);
		$display("test warning done");
		apb(1'b1, pfs_pkg::ADDR_WAKE, 32'h3);
		apb(1'b1, pfs_pkg::ADDR_CTRL, 32'h41);
		idle(5);
		chk("halted", 32'h1, 32'(cpuHalted));
		chk("monOff", 32'h0, 32'(monitorOn));
		waitfor(cpuHalted, 1'b0, 1000);
		chk("timerLen", 32'h1, 32'(wcnt >= 80));
		rdc("statTimer", pfs_pkg::ADDR_STAT, 32'h2);
		apb(1'b1, pfs_pkg::ADDR_WAKE, 32'h0);
		for (int p = 1; p >= 0; p--) begin
			apb(1'b1, pfs_pkg::ADDR_CTRL, 32'(64 + p));
			idle(5);
			setv(1750, 0);
			idle(100);
			chk("stillHalted", 32'(p), 32'(cpuHalted));
			ioIrqReq <= 1'b1;
			waitfor(cpuHalted, 1'b0, 1000);
			ioIrqReq <= 1'b0;
			setv(3300, 0);
			rdc("statStop", pfs_pkg::ADDR_STAT, 32'h1);
		end
		$display("test stop done");
		setv(1600, 0);
		idle(20);
		chk("pfRst", 32'h0, 32'(cpuReset_n));
		chk("pfPower", 32'h1, 32'({crystalOn, regulatorOn, sramRetain}));
		setv(3300, 0);
		idle(60);
		chk("pfHold", 32'h0, 32'(cpuReset_n));
		waitfor(cpuReset_n, 1'b1, 2000);
		chk("vector", 32'h8000, 32'(resetVector));
		rdc("statPfRst", pfs_pkg::ADDR_STAT, 32'h4);
		apb(1'b1, pfs_pkg::ADDR_CTRL, 32'h7);
		extResetReq <= 1'b1;
		idle(5);
		chk("extRst", 32'h0, 32'(cpuReset_n));
		chk("extOn", 32'h7, 32'({monitorOn, regulatorOn, crystalOn}));
		extResetReq <= 1'b0;
		waitfor(cpuReset_n, 1'b1, 100);
		chk("extExit", 32'h1, 32'(wcnt < 20));
		rdc("ctrlKept", pfs_pkg::ADDR_CTRL, 32'h7);
		setv(1000, 0);
		idle(10);
		chk("por", 32'h0, 32'(cpuReset_n));
		setv(3300, 0);
		waitfor(cpuReset_n, 1'b1, 3000);
		rdc("ctrlPor", pfs_pkg::ADDR_CTRL, 32'h1);
		$display("test resets done");
		apb(1'b1, pfs_pkg::ADDR_MASK, 32'h1);
		setv(1750, 0);
		idle(20);
		chk("irqOn", 32'h1, 32'(irq));
		apb(1'b1, pfs_pkg::ADDR_MASK, 32'h0);
		idle(2);
		chk("irqMasked", 32'h0, 32'(irq));
		setv(3300, 0);
		rdc("statIrq", pfs_pkg::ADDR_STAT, 32'h1);
		rdc("statClr", pfs_pkg::ADDR_STAT, 32'h0);
		$display("test interrupt done");
		wrap_up();
	end
endmodule : pfs_sequencer_test
